/* File: bench/mgmt_link_monitor.sv */
// concurrent checks on the management link between controller and device
`timescale 1ns/100ps
`default_nettype none
module mgmt_link_monitor (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic mdc,
  input wire logic host_o,
  input wire logic host_oe,
  input wire logic dev_o,
  input wire logic dev_oe,
  input wire logic mdio
);
  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  logic [6:0] rise_cnt_r;  // link clock rises since the frame began
  logic [7:0] oe_cnt_r;    // cycles the device has driven the line
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // restart at the frame start, count each link clock rise
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      rise_cnt_r <= '0;
    else if ($rose(host_oe))
      rise_cnt_r <= '0;
    else if ($rose(mdc))
      rise_cnt_r <= rise_cnt_r + 7'h01;
  // length of the current device drive burst
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      oe_cnt_r <= '0;
    else
      oe_cnt_r <= dev_oe ? oe_cnt_r + 8'h01 : 8'h00;
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  no_contention_a: assert property (!(host_oe && dev_oe))
    else $error("both ends drive the data line");
  clk_high_a: assert property ($rose(mdc) |-> mdc [*4] ##1 !mdc)
    else $error("link clock high phase wrong");
  clk_low_a: assert property ($fell(mdc) |-> !mdc [*4])
    else $error("link clock low phase too short");
  host_hold_a: assert property (mdc && $past(mdc) |-> $stable(host_o))
    else $error("controller data moved while clock high");
  dev_hold_a: assert property ($rose(mdc) |-> $stable(dev_o) && $stable(dev_oe))
    else $error("device data moved at clock rise");
  preamble_ones_a: assert property ($rose(mdc) && host_oe && rise_cnt_r < 7'h20 |-> mdio)
    else $error("preamble bit not one");
  start_bits_a: assert property ($rose(mdc) && host_oe && rise_cnt_r == 7'h20
    |-> !mdio ##8 mdio)
    else $error("start pattern wrong");
  release_point_a: assert property ($fell(host_oe) |-> rise_cnt_r == 7'h2E
    || rise_cnt_r == 7'h40)
    else $error("controller released at wrong bit");
  read_turn_a: assert property ($fell(host_oe) && rise_cnt_r == 7'h2E |-> !dev_oe [*6])
    else $error("device drove the first turnaround bit");
  write_turn_a: assert property ($rose(mdc) && host_oe && rise_cnt_r == 7'h2E
    |-> mdio ##8 !mdio)
    else $error("write turnaround not one then zero");
  turn_zero_a: assert property ($rose(dev_oe) |-> !dev_o)
    else $error("device turnaround bit not zero");
  drive_len_a: assert property ($fell(dev_oe) |-> oe_cnt_r >= 8'h86
    && oe_cnt_r <= 8'h8A)
    else $error("device drive burst wrong length");
  // main scenarios seen
  read_frame_c: cover property ($fell(host_oe) && rise_cnt_r == 7'h2E);
  write_frame_c: cover property ($fell(host_oe) && rise_cnt_r == 7'h40);
  dev_drive_c: cover property ($rose(dev_oe));
endmodule // mgmt_link_monitor
`default_nettype wire

/* File: bench/switch_mdio_register_access_tb.sv */
// self-checking bench: controller and device ends facing across the link
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fails++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module switch_mdio_register_access_tb;
  import mgmt_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clk, reset_n, req_valid, req_ready_r, resp_valid_r;
  kind_t       req_kind;       // access kind offered
  logic [4:0]  req_dev, req_reg;
  logic [15:0] req_wdata, resp_rdata_r, wr_data_r;
  logic        wr_pulse_r, wr_ext_r, wr2_pulse;
  logic [7:0]  wr_addr_r, wr2_addr;
  logic [64:0] cap = '0;       // last 65 bits seen on the line
  int          n_wr = 0, n_wr2 = 0, n_rd = 0, cyc = 0, fails = 0, n_tests = 0;
  mgmt_link_if link ();        // link between the two design ends
  mgmt_link_if link2 ();       // link to a rule-breaking bench driver
  mgmt_host mgmt_host_i (.clk(clk), .reset_n(reset_n), .link(link.host),
    .req_valid(req_valid), .req_ready_r(req_ready_r), .req_kind(req_kind),
    .req_dev(req_dev), .req_reg(req_reg), .req_wdata(req_wdata),
    .resp_valid_r(resp_valid_r), .resp_rdata_r(resp_rdata_r));
  mgmt_dev mgmt_dev_i (.clk(clk), .reset_n(reset_n), .link(link.dev),
    .wr_pulse_r(wr_pulse_r), .wr_ext_r(wr_ext_r), .wr_addr_r(wr_addr_r), .wr_data_r(wr_data_r));
  mgmt_dev fault_mgmt_dev_i (.clk(clk), .reset_n(reset_n), .link(link2.dev),
    .wr_pulse_r(wr2_pulse), .wr_ext_r(), .wr_addr_r(wr2_addr), .wr_data_r());
  mgmt_link_monitor mgmt_link_monitor_i (.clk(clk), .reset_n(reset_n), .mdc(link.mdc),
    .host_o(link.host_o), .host_oe(link.host_oe), .dev_o(link.dev_o),
    .dev_oe(link.dev_oe), .mdio(link.mdio));
  // ----------------------------------------------------------------
  // observers and timeout
  // ----------------------------------------------------------------
  // shift the resolved line in at every link clock rise
  always @(posedge link.mdc)
    cap <= {cap[63:0], link.mdio};
  // count pulses per cycle so a stretched pulse shows up
  always @(posedge clk)
  begin
    n_wr <= n_wr + int'(wr_pulse_r === 1'b1);
    n_wr2 <= n_wr2 + int'(wr2_pulse === 1'b1);
    n_rd <= n_rd + int'(resp_valid_r === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      print_verdict();
    end
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  // report counts and end the run
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // one frame through the controller; judge the line and the answer
  task automatic xfer(input kind_t k, input logic [4:0] d, input logic [4:0] r,
                      input logic [15:0] wd, input logic [15:0] ed, input logic [1:0] ta);
    int n, w0, r0;
    logic [1:0] op;
    w0 = n_wr;
    r0 = n_rd;
    op = (k == K_STD_RD) ? OP_RD : (k == K_STD_WR) ? OP_WR : OP_EXT;
    req_valid <= 1'b1;
    req_kind <= k;
    req_dev <= d;
    req_reg <= r;
    req_wdata <= wd;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (req_ready_r !== 1'b1 && n < 20);
    req_valid <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (req_ready_r !== 1'b1 && n < 700);
    repeat (2) @(posedge clk);
    `CHK(cap, {32'hFFFFFFFF, START_BITS, op, d, r, ta, ed, 1'b1})
    if (k == K_STD_WR || k == K_EXT_WR)
      `CHK(n_wr - w0, 1)
    else
    begin
      `CHK(n_rd - r0, 1)
      `CHK(resp_rdata_r, ed)
    end
  endtask
  // all eight standard registers, then silent places
  task automatic t_std();
    logic [4:0] r;
    for (int i = 0; i < 16; i++)
    begin
      r = (i % 8 < 6) ? 5'(i % 8) : (i % 8 == 6) ? CUST_A : CUST_B;
      xfer(i < 8 ? K_STD_WR : K_STD_RD, DEV_ADDR_DEF, r, {8'hA0 + 8'(i % 8), 8'h5C},
           {8'hA0 + 8'(i % 8), 8'h5C}, TA_WR);
      `CHK(wr_addr_r, (i < 8) ? {3'h0, r} : {3'h0, CUST_B})
      `CHK(wr_ext_r, 1'b0)
    end
    xfer(K_STD_RD, DEV_ADDR_DEF, 5'h06, 16'h0000, 16'hFFFF, 2'h3);
    xfer(K_STD_RD, 5'h02, 5'h01, 16'h0000, 16'hFFFF, 2'h3);
  endtask
  // extended frames at both ends of the config range
  task automatic t_ext();
    logic [7:0] a;
    for (int i = 0; i < 2; i++)
    begin
      a = i ? CFG_LAST : 8'h00;
      xfer(K_EXT_WR, {1'b0, 1'(i), a[7:5]}, a[4:0], {8'hFF, 8'h3C ^ a},
           {8'hFF, 8'h3C ^ a}, TA_WR);
      `CHK(wr_addr_r, a)
      `CHK(wr_data_r, {8'h00, 8'h3C ^ a})
      `CHK(wr_ext_r, 1'b1)
      xfer(K_EXT_RD, {1'b1, 1'(~i), a[7:5]}, a[4:0], 16'h0000,
           {8'h00, 8'h3C ^ a}, TA_WR);
    end
    xfer(K_EXT_RD, 5'h12, 5'h05, 16'h0000, 16'h0000, TA_WR);
    xfer(K_EXT_RD, 5'h17, 5'h04, 16'h0000, 16'h005C, TA_WR);
    xfer(K_EXT_RD, 5'h1F, 5'h05, 16'h0000, 16'h00A2, TA_WR);
    // byte write through the indirect window lands in transceiver reg 3
    xfer(K_EXT_WR, 5'h07, 5'h06, 16'h0077, 16'h0077, TA_WR);
    `CHK(wr_addr_r, 8'hE6)
    xfer(K_STD_RD, DEV_ADDR_DEF, 5'h03, 16'h0000, 16'hA377, TA_WR);
    // address above the config range and outside the window: no answer
    xfer(K_EXT_RD, 5'h14, 5'h10, 16'h0000, 16'hFFFF, 2'h3);
  endtask
  // bench drives the second link bit by bit, preamble length chosen
  task automatic bang(input int npre);
    logic [31:0] f;
    f = {START_BITS, OP_WR, DEV_ADDR_DEF, 5'h03, TA_WR, 16'h5A5A};
    for (int i = npre + 31; i >= -1; i--)
    begin
      link2.host_oe <= (i >= 0);
      link2.host_o <= (i > 31) || (i >= 0 && f[i[4:0]]);
      repeat (4) @(posedge clk);
      link2.mdc <= 1'b1;
      repeat (4) @(posedge clk);
      link2.mdc <= 1'b0;
    end
  endtask
  // short preamble is ignored, full one is served
  task automatic t_fault();
    int w0;
    w0 = n_wr2;
    bang(31);
    repeat (4) @(posedge clk);
    `CHK(n_wr2 - w0, 0)
    bang(32);
    repeat (4) @(posedge clk);
    `CHK(n_wr2 - w0, 1)
    `CHK(wr2_addr, 8'h03)
  endtask
  // ----------------------------------------------------------------
  // clock and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    reset_n = 1'b0;
    req_valid = 1'b0;
    req_kind = K_STD_RD;
    req_dev = 5'h00;
    req_reg = 5'h00;
    req_wdata = 16'h0000;
    link2.mdc = 1'b0;
    link2.host_o = 1'b1;
    link2.host_oe = 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_std();
    t_ext();
    t_fault();
    print_verdict();
  end
endmodule // switch_mdio_register_access_tb
`default_nettype wire

/* File: design/mgmt_dev.sv */
// device end: parses management frames and serves its registers
// What this block does
// - frame: 32 ones, 01, op, addresses, turnaround, data
// - standard frames reach registers 0-5, 29, 31
// - controller clock plus one shared data line
// - extended frames reach config 0x00-0x8D, indirect transceivers
// - op 00, device address bit4 one: read
// - op 00, device address bit4 zero: write
// - device address bit3 ignored on extended access
// - config address = low device bits, register bits
// - config registers eight bits, low data byte
// - extended read returns zero upper byte
// - extended write ignores upper data byte
// - extended frames share standard frame sequencing
`timescale 1ns/100ps
`default_nettype none
module mgmt_dev #(
  parameter logic [4:0] DEV_ADDR = mgmt_pkg::DEV_ADDR_DEF // standard address
) (
  input  wire logic  clk,
  input  wire logic  reset_n,
  mgmt_link_if.dev   link,              // management link
  output logic       wr_pulse_r,        // a register was written
  output logic       wr_ext_r,          // write came by extended frame
  output logic [7:0] wr_addr_r,         // written address
  output logic [15:0] wr_data_r         // written data
);
  import mgmt_pkg::*;

  typedef enum logic [2:0] {S_PRE, S_ST1, S_HDR, S_TA1, S_TA2, S_DATA} state_t;

  logic              mdc_s;             // synchronised clock line
  logic              mdio_s;            // synchronised data line
  logic              mdc_d_r;           // previous clock level
  logic              rise;              // rising edge seen
  state_t            state_r;           // frame position
  logic [5:0]        ones_r;            // preamble ones, saturating
  logic [3:0]        cnt_r;             // bit count in field
  logic [11:0]       hdr_r;             // op, device, register address
  logic [15:0]       wd_r;              // incoming data bits
  logic [15:0]       sh_r;              // outgoing read data
  logic              oe_r;              // device drive enable
  logic              o_r;               // device data
  logic [7:0]        cfg_mem [CFG_NUM]; // configuration registers
  logic [15:0]       std_mem [STD_NUM]; // transceiver registers
  logic [1:0]        op;                // decoded opcode
  logic [4:0]        dev_a;             // device address field
  logic [4:0]        reg_a;             // register address field
  logic [7:0]        ext_a;             // extended register address
  logic [2:0]        slot;              // transceiver slot
  logic              slot_ok;           // register number exists
  logic              is_ext;            // extended frame
  logic              std_hit;           // standard frame for us
  logic              cfg_ok;            // config address in range
  logic              ind_ok;            // indirect window address
  logic              rd_go;             // frame is a read we answer
  logic [15:0]       rd_word;           // word to return
  logic [15:0]       wr_word;           // word just completed
  logic [7:0]        ind_byte;          // byte of indirect read

  // ----------------------------------------------------------------
  // line sampling
  // ----------------------------------------------------------------
  sig_sync #(.W(2)) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .d       ({link.mdc, link.mdio}),
    .q       ({mdc_s, mdio_s})
  );

  // remember clock level to find its rising edge
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      mdc_d_r <= 1'b0;
    else
      mdc_d_r <= mdc_s;
  end

  assign rise = mdc_s & ~mdc_d_r;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign op      = hdr_r[11:10];
  assign dev_a   = hdr_r[9:5];
  assign reg_a   = hdr_r[4:0];
  assign ext_a   = {dev_a[2:0], reg_a};
  assign is_ext  = (op == OP_EXT);
  assign cfg_ok  = (ext_a <= CFG_LAST);
  assign ind_ok  = (ext_a[7:4] == IND_PAGE);
  assign wr_word = {wd_r[14:0], mdio_s};

  // map register number to slot; 0..5 then 29, 31
  always_comb
  begin
    slot    = reg_a[2:0];
    slot_ok = (reg_a <= STD_LAST);
    if (reg_a == CUST_A)
    begin
      slot    = 3'h6;
      slot_ok = 1'b1;
    end
    else if (reg_a == CUST_B)
    begin
      slot    = 3'h7;
      slot_ok = 1'b1;
    end
  end

  assign std_hit = (op == OP_RD || op == OP_WR) && (dev_a == DEV_ADDR) && slot_ok;
  assign rd_go   = (op == OP_RD && std_hit)
                 || (is_ext && dev_a[EXT_RD_BIT] && (cfg_ok || ind_ok));

  // pick the byte of an indirect transceiver register
  assign ind_byte = ext_a[0] ? std_mem[ext_a[3:1]][15:8] : std_mem[ext_a[3:1]][7:0];

  // word returned on a read
  always_comb
  begin
    if (!is_ext)
      rd_word = std_mem[slot];
    else if (cfg_ok)
      rd_word = {8'h00, cfg_mem[ext_a]};
    else
      rd_word = {8'h00, ind_byte};
  end

  // ----------------------------------------------------------------
  // frame parser
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= S_PRE;
      ones_r  <= '0;
      cnt_r   <= '0;
      hdr_r   <= '0;
      wd_r    <= '0;
    end
    else if (rise)
    begin
      unique case (state_r)
        // count ones; a zero after enough ones is the start bit
        S_PRE:
        begin
          if (mdio_s)
            ones_r <= (ones_r == 6'(PRE_LEN)) ? ones_r : ones_r + 6'h01;
          else if (ones_r == 6'(PRE_LEN))
          begin
            state_r <= S_ST1;
            ones_r  <= '0;
          end
          else
            ones_r <= '0;
        end
        // second start bit must be one
        S_ST1:
        begin
          state_r <= (mdio_s == START_BITS[0]) ? S_HDR : S_PRE;
          cnt_r   <= '0;
        end
        // opcode and both address fields
        S_HDR:
        begin
          hdr_r <= {hdr_r[10:0], mdio_s};
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == 4'(HDR_BITS - 1))
            state_r <= S_TA1;
        end
        S_TA1:
          state_r <= S_TA2;
        // turnaround done, data follows
        S_TA2:
        begin
          state_r <= S_DATA;
          cnt_r   <= '0;
        end
        // data bits, frame ends after the sixteenth
        S_DATA:
        begin
          wd_r  <= wr_word;
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == 4'(DATA_BITS - 1))
            state_r <= S_PRE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // line driver: turnaround zero then data, released at frame end
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      oe_r <= 1'b0;
      o_r  <= 1'b0;
      sh_r <= '0;
    end
    else if (rise)
    begin
      if (state_r == S_TA1 && rd_go)
      begin
        oe_r <= 1'b1;
        o_r  <= 1'b0;
        sh_r <= rd_word;
      end
      else if (oe_r && (state_r == S_TA2
               || (state_r == S_DATA && cnt_r != 4'(DATA_BITS - 1))))
      begin
        o_r  <= sh_r[15];
        sh_r <= {sh_r[14:0], 1'b0};
      end
      else
      begin
        oe_r <= 1'b0;
        o_r  <= 1'b0;
      end
    end
  end

  assign link.dev_oe = oe_r;
  assign link.dev_o  = o_r;

  // ----------------------------------------------------------------
  // register writes at the last data bit
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < CFG_NUM; i++)
        cfg_mem[i] <= CFG_RST;
      for (int i = 0; i < STD_NUM; i++)
        std_mem[i] <= STD_RST;
      wr_pulse_r <= 1'b0;
      wr_ext_r   <= 1'b0;
      wr_addr_r  <= '0;
      wr_data_r  <= '0;
    end
    else
    begin
      wr_pulse_r <= 1'b0;
      if (rise && state_r == S_DATA && cnt_r == 4'(DATA_BITS - 1))
      begin
        if (op == OP_WR && std_hit)
        begin
          std_mem[slot] <= wr_word;
          wr_pulse_r    <= 1'b1;
          wr_ext_r      <= 1'b0;
          wr_addr_r     <= {3'h0, reg_a};
          wr_data_r     <= wr_word;
        end
        else if (is_ext && !dev_a[EXT_RD_BIT] && (cfg_ok || ind_ok))
        begin
          if (cfg_ok)
            cfg_mem[ext_a] <= wr_word[7:0];
          else if (ext_a[0])
            std_mem[ext_a[3:1]][15:8] <= wr_word[7:0];
          else
            std_mem[ext_a[3:1]][7:0] <= wr_word[7:0];
          wr_pulse_r <= 1'b1;
          wr_ext_r   <= 1'b1;
          wr_addr_r  <= ext_a;
          wr_data_r  <= {8'h00, wr_word[7:0]};
        end
      end
    end
  end
endmodule // mgmt_dev
`default_nettype wire

/* File: design/mgmt_host.sv */
// controller end: makes the management clock and runs frames
`timescale 1ns/100ps
`default_nettype none
module mgmt_host (
  input  wire logic         clk,
  input  wire logic         reset_n,
  mgmt_link_if.host         link,       // management link
  input  wire logic         req_valid,  // request offered
  output logic              req_ready_r,// idle, request accepted
  input  wire mgmt_pkg::kind_t req_kind,// access kind
  input  wire logic [4:0]   req_dev,    // device address field
  input  wire logic [4:0]   req_reg,    // register address field
  input  wire logic [15:0]  req_wdata,  // write data
  output logic              resp_valid_r, // read data ready, one cycle
  output logic [15:0]       resp_rdata_r  // read data
);
  import mgmt_pkg::*;

  logic              mdio_s;            // synchronised data line
  logic              busy_r;            // frame running
  logic              rd_r;              // frame is a read
  logic [2:0]        div_r;             // half period counter
  logic              mdc_r;             // clock out
  logic [6:0]        cnt_r;             // bit index in frame
  logic [FRAME_BITS-1:0] fr_r;          // outgoing frame bits
  logic              o_r;               // data out
  logic              oe_r;              // drive enable
  logic [1:0]        op;                // opcode to send
  logic [4:0]        dev_f;             // device field to send
  logic [1:0]        ta;                // turnaround to send
  logic              is_rd;             // request is a read
  logic              tick;              // half period over
  logic [6:0]        nxt;               // next bit index

  sig_sync #(.W(1)) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .d       (link.mdio),
    .q       (mdio_s)
  );

  // ----------------------------------------------------------------
  // frame assembly
  // ----------------------------------------------------------------
  always_comb
  begin
    op    = OP_EXT;
    dev_f = req_dev;
    is_rd = 1'b0;
    unique case (req_kind)
      K_STD_RD:
      begin
        op    = OP_RD;
        is_rd = 1'b1;
      end
      K_STD_WR:
        op = OP_WR;
      K_EXT_RD:
      begin
        dev_f[EXT_RD_BIT] = 1'b1;
        is_rd             = 1'b1;
      end
      K_EXT_WR:
        dev_f[EXT_RD_BIT] = 1'b0;
    endcase
    ta = is_rd ? 2'h0 : TA_WR;
  end

  assign tick = (div_r == 3'(MDC_HALF - 1));
  assign nxt  = cnt_r + 7'h01;

  // ----------------------------------------------------------------
  // clock divider and bit sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      busy_r       <= 1'b0;
      req_ready_r  <= 1'b0;
      rd_r         <= 1'b0;
      div_r        <= '0;
      mdc_r        <= 1'b0;
      cnt_r        <= '0;
      fr_r         <= '0;
      o_r          <= 1'b0;
      oe_r         <= 1'b0;
      resp_valid_r <= 1'b0;
      resp_rdata_r <= '0;
    end
    else
    begin
      resp_valid_r <= 1'b0;
      req_ready_r  <= !busy_r && !(req_valid && req_ready_r);
      if (!busy_r)
      begin
        // take request; first preamble bit goes out at once
        if (req_valid && req_ready_r)
        begin
          busy_r <= 1'b1;
          rd_r   <= is_rd;
          div_r  <= '0;
          cnt_r  <= '0;
          fr_r   <= {{PRE_LEN{1'b1}}, START_BITS, op, dev_f, req_reg, ta,
                     is_rd ? 16'h0000 : req_wdata};
          o_r    <= 1'b1;
          oe_r   <= 1'b1;
          resp_rdata_r <= '0;
        end
      end
      else
      begin
        div_r <= tick ? 3'h0 : div_r + 3'h1;
        if (tick && !mdc_r)
        begin
          // rising edge: the device samples, we sample read data
          mdc_r <= 1'b1;
          if (rd_r && cnt_r >= 7'(DATA_POS) && cnt_r < 7'(FRAME_BITS))
            resp_rdata_r <= {resp_rdata_r[14:0], mdio_s};
        end
        else if (tick)
        begin
          // falling edge: present the next bit
          mdc_r <= 1'b0;
          cnt_r <= nxt;
          fr_r  <= {fr_r[FRAME_BITS-2:0], 1'b0};
          o_r   <= fr_r[FRAME_BITS-2];
          oe_r  <= (nxt < 7'(FRAME_BITS)) && !(rd_r && nxt >= 7'(TA_POS));
          if (cnt_r == 7'(FRAME_BITS))
          begin
            // idle bit done, line left floating
            busy_r       <= 1'b0;
            oe_r         <= 1'b0;
            resp_valid_r <= rd_r;
          end
        end
      end
    end
  end

  assign link.mdc     = mdc_r;
  assign link.host_o  = o_r;
  assign link.host_oe = oe_r;
endmodule // mgmt_host
`default_nettype wire

/* File: design/mgmt_link_if.sv */
// two-wire management link joining controller and device
`timescale 1ns/100ps
`default_nettype none
interface mgmt_link_if;
  logic mdc;      // clock, made by the controller
  logic host_o;   // controller data out
  logic host_oe;  // controller drives data line
  logic dev_o;    // device data out
  logic dev_oe;   // device drives data line
  logic mdio;     // resolved line, pulled high when nobody drives
  assign mdio = dev_oe ? dev_o : (host_oe ? host_o : 1'b1);
  modport dev  (input mdc, input mdio, output dev_o, output dev_oe);
  modport host (output mdc, output host_o, output host_oe, input mdio);
endinterface
`default_nettype wire

/* File: design/mgmt_pkg.sv */
// shared constants and types for the two-wire management link
package mgmt_pkg;
  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int         PRE_LEN    = 32;      // preamble ones
  localparam int         HDR_BITS   = 12;      // op, device and register addr
  localparam int         DATA_BITS  = 16;      // data field
  localparam int         FRAME_BITS = 64;      // preamble to last data bit
  localparam int         TA_POS     = 46;      // first turnaround bit
  localparam int         DATA_POS   = 48;      // first data bit
  localparam logic [1:0] START_BITS = 2'h1;    // start pattern 01
  localparam logic [1:0] OP_RD      = 2'h2;    // standard read
  localparam logic [1:0] OP_WR      = 2'h1;    // standard write
  localparam logic [1:0] OP_EXT     = 2'h0;    // extended access
  localparam logic [1:0] TA_WR      = 2'h2;    // write turnaround 10
  localparam int         EXT_RD_BIT = 4;       // device addr bit: 1 = read
  // ----------------------------------------------------------------
  // register spaces
  // ----------------------------------------------------------------
  localparam int         CFG_NUM      = 142;   // config registers
  localparam logic [7:0] CFG_LAST     = 8'h8D; // last config address
  localparam logic [7:0] CFG_RST      = 8'h00; // config reset value
  localparam int         STD_NUM      = 8;     // transceiver registers
  localparam logic [15:0] STD_RST     = 16'h0000;
  localparam logic [4:0] STD_LAST     = 5'h05; // standard regs 0..5
  localparam logic [4:0] CUST_A       = 5'h1D; // custom register 29
  localparam logic [4:0] CUST_B       = 5'h1F; // custom register 31
  localparam logic [3:0] IND_PAGE     = 4'hE;  // indirect window 0xE0..0xEF
  localparam logic [4:0] DEV_ADDR_DEF = 5'h01; // standard device address
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS   = 100;               // system clock period
  localparam int MDC_NS   = 800;               // management clock period
  localparam int MDC_HALF = MDC_NS / (2 * CLK_NS);
  // request kinds of the controller end
  typedef enum logic [1:0] {K_STD_RD, K_STD_WR, K_EXT_RD, K_EXT_WR} kind_t;
endpackage

/* File: design/sig_sync.sv */
// two-flop synchroniser for signals from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module sig_sync #(
  parameter int W = 1                    // number of bits
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] d,           // asynchronous inputs
  output logic      [W-1:0] q            // synchronised levels
);
  logic [W-1:0] meta_r;                  // first stage, read only by q
  // ----------------------------------------------------------------
  // two stages
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // sig_sync
`default_nettype wire
